// ### dapsc_top.sv
// Purpose: Control port with register file and serial audio input port of a stereo converter.
// Assumes: core_clk_i at 25 MHz; master_clk_i is the audio master clock and clocks the port.
// Notes:   Configuration and received sample pairs cross between the domains by toggles.
`timescale 1ns/1ps
`default_nettype none
`include "dapsc_map.svh"

////////////////////////////////////////////////////////////////////////////////
// Operation
// - A control frame is 24 bits: read flag, 7-bit address, 16 data bits.
// - Each rising shift clock edge shifts one bit in from the data line.
// - Select rising takes the last 24 shifted bits as one frame.
// - On reads data-in is ignored after the address; data goes out serially.
// - Volume-update addresses 06h and 07h are not accessible in this mode.
// - Any write to address 00h returns all register bits to defaults.
// - Reading address 00h returns the fixed 16-bit part identifier.
// - Reading address 01h returns the 3-bit silicon revision in low bits.
// - Master select 0 means clocks are inputs; 1 means generated. Default 0.
// - Frame format bits pick right, left justified, I2S or DSP; reset I2S.
// - Word length bits pick 16, 20, 24 or 32 bits; reset 24.
// - Bit clock invert picks sampling edge as slave, output polarity as master.
// - Right justified: LSB on last rising edge before a frame transition.
// - Left justified: MSB on first rising edge after a frame transition.
// - I2S: MSB on second rising edge after a frame transition.
// - DSP: left MSB on edge 1 (B) or 2 (A); right follows directly.
// - Ratio bits set master clock to frame clock ratio, 128fs to 1152fs.
// - Master bit clock divider: mclk/4, mclk/8, 32fs, 64fs, 128fs.
// - Data and frame are sampled on rising bit clock unless inverted.
// - Frame clock invert bit flips polarity; in DSP it selects mode A or B.
module dapsc_top #(
  parameter logic [15:0] PART_ID     = 16'h5a3c,  // Arbitrary identity value.
  parameter logic [2:0]  SILICON_REV = 3'h1       // Arbitrary revision value.
) (
  input  wire logic        core_clk_i,
  input  wire logic        reset_n_i,
  input  wire logic        master_clk_i,
  input  wire logic        control_port_select_i,
  input  wire logic        control_shift_clock_i,
  input  wire logic        control_data_in_i,
  input  wire logic        control_select_n_i,
  input  wire logic        serial_audio_in_i,
  input  wire logic        bit_clock_i,
  input  wire logic        frame_clock_i,
  output logic             control_read_out_o,
  output logic             bit_clock_o,
  output logic             bit_clock_oe_n_o,
  output logic             frame_clock_o,
  output logic             frame_clock_oe_n_o,
  output logic [31:0]      sample_left_o,
  output logic [31:0]      sample_right_o,
  output logic             sample_valid_o
);

  function automatic dapsc_pkg::dapsc_cfg_t cfg_of(input logic [15:0] a1,
                                                    input logic [15:0] a2);
    dapsc_pkg::dapsc_cfg_t c;
    c.master   = a1[`DAPSC_MSTR_BIT];
    c.lr_inv   = a1[`DAPSC_LINV_BIT];
    c.bclk_inv = a1[`DAPSC_BINV_BIT];
    c.wl       = a1[`DAPSC_WL_LSB +: 2];
    c.fmt      = dapsc_pkg::dapsc_fmt_t'(a1[`DAPSC_FMT_LSB +: 2]);
    c.bdiv     = a2[`DAPSC_BDIV_LSB +: 3];
    c.ratio    = a2[`DAPSC_RATIO_LSB +: 3];
    return c;
  endfunction : cfg_of

  localparam dapsc_pkg::dapsc_cfg_t CFG_RESET = cfg_of(`DAPSC_AIF1_RESET, `DAPSC_AIF2_RESET);

  //////////////////////////////////////////////////////////////////////////////
  // Control port, core clock domain.
  logic [2:0]            sclk_s;
  logic [2:0]            cs_s;
  logic [1:0]            sdi_s;
  logic [1:0]            mode_s;
  logic [23:0]           shreg;
  logic [3:0]            hdr_cnt;
  logic [15:0]           rd_shift;
  logic                  rd_active;
  logic [15:0]           aif1;
  logic [15:0]           aif2;
  dapsc_pkg::dapsc_spi_t state;
  dapsc_pkg::dapsc_spi_t next_state;

  // The first stage of each synchroniser feeds only its second stage.
  always_ff @(posedge core_clk_i) begin
    sclk_s <= {sclk_s[1:0], control_shift_clock_i};
    cs_s   <= {cs_s[1:0], control_select_n_i};
    sdi_s  <= {sdi_s[0], control_data_in_i};
    mode_s <= {mode_s[0], control_port_select_i};
  end

  wire       sclk_rise = sclk_s[1] & ~sclk_s[2];
  wire       sclk_fall = ~sclk_s[1] & sclk_s[2];
  wire       spi_on    = mode_s[1] & ~cs_s[1];
  wire       cs_rise   = mode_s[1] & cs_s[1] & ~cs_s[2];
  wire       hdr_done  = spi_on & sclk_rise & (state == dapsc_pkg::DAPSC_SPI_HEAD)
                         & (hdr_cnt == `DAPSC_HDR_LAST);
  wire       hdr_rw    = shreg[6];
  wire [6:0] hdr_addr  = {shreg[5:0], sdi_s[1]};
  wire       commit    = cs_rise & (state == dapsc_pkg::DAPSC_SPI_BODY)
                         & ~shreg[`DAPSC_RW_BIT];
  wire [6:0] wr_addr   = shreg[`DAPSC_ADDR_LSB +: 7];
  wire [15:0] wr_data  = shreg[15:0];
  wire       wr_reset  = commit & (wr_addr == `DAPSC_ADDR_RESET);
  wire       wr_aif1   = commit & (wr_addr == `DAPSC_ADDR_AIF1);
  wire       wr_aif2   = commit & (wr_addr == `DAPSC_ADDR_AIF2);
  // Volume-update addresses decode to nothing here: reads give zero, writes drop.
  wire [15:0] rd_value = (hdr_addr == `DAPSC_ADDR_RESET) ? PART_ID :
                         (hdr_addr == `DAPSC_ADDR_REV)   ? {13'h0000, SILICON_REV} :
                         (hdr_addr == `DAPSC_ADDR_AIF1)  ? aif1 :
                         (hdr_addr == `DAPSC_ADDR_AIF2)  ? aif2 : 16'h0000;

  always_comb begin
    next_state = state;
    unique case (state)
      dapsc_pkg::DAPSC_SPI_IDLE: if (spi_on) next_state = dapsc_pkg::DAPSC_SPI_HEAD;
      dapsc_pkg::DAPSC_SPI_HEAD: if (!spi_on) begin
        next_state = dapsc_pkg::DAPSC_SPI_IDLE;
      end else if (hdr_done) begin
        next_state = dapsc_pkg::DAPSC_SPI_BODY;
      end
      dapsc_pkg::DAPSC_SPI_BODY: if (!spi_on) next_state = dapsc_pkg::DAPSC_SPI_IDLE;
      default: next_state = dapsc_pkg::DAPSC_SPI_IDLE;
    endcase
  end

  always_ff @(posedge core_clk_i) begin
    if (!reset_n_i) begin
      state   <= dapsc_pkg::DAPSC_SPI_IDLE;
      hdr_cnt <= 4'h0;
      shreg   <= 24'h000000;
    end else begin
      state   <= next_state;
      hdr_cnt <= (state != dapsc_pkg::DAPSC_SPI_HEAD) ? 4'h0 : hdr_cnt + {3'h0, sclk_rise};
      if (spi_on && sclk_rise) shreg <= {shreg[22:0], sdi_s[1]};
    end
  end

  // After the address of a read frame the input is not looked at for the reply.
  always_ff @(posedge core_clk_i) begin
    if (!reset_n_i || cs_s[1]) begin
      rd_active          <= 1'b0;
      rd_shift           <= 16'h0000;
      control_read_out_o <= 1'b0;
    end else if (hdr_done && hdr_rw) begin
      rd_active <= 1'b1;
      rd_shift  <= rd_value;
    end else if (rd_active && sclk_fall) begin
      control_read_out_o <= rd_shift[15];
      rd_shift           <= {rd_shift[14:0], 1'b0};
    end
  end

  always_ff @(posedge core_clk_i) begin
    if (!reset_n_i || wr_reset) begin
      aif1 <= `DAPSC_AIF1_RESET;
      aif2 <= `DAPSC_AIF2_RESET;
    end else begin
      if (wr_aif1) aif1 <= wr_data & `DAPSC_AIF1_MASK;
      if (wr_aif2) aif2 <= wr_data & `DAPSC_AIF2_MASK;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Configuration handshake into the audio domain; the held copy stays still
  // until the far side has acknowledged it, so it can be taken as a word.
  dapsc_pkg::dapsc_cfg_t cfg_hold;
  logic                  req_tgl;
  logic [1:0]            ack_s;
  logic [2:0]            req_s;
  logic [1:0]            lrst_s;
  dapsc_pkg::dapsc_cfg_t cfg;
  wire                   cfg_idle = (ack_s[1] == req_tgl);
  wire                   link_rst_n = lrst_s[1];

  always_ff @(posedge core_clk_i) begin
    ack_s <= {ack_s[0], req_s[2]};
    if (!reset_n_i) begin
      cfg_hold <= CFG_RESET;
      req_tgl  <= 1'b0;
    end else if (cfg_idle && (cfg_hold != cfg_of(aif1, aif2))) begin
      cfg_hold <= cfg_of(aif1, aif2);
      req_tgl  <= ~req_tgl;
    end
  end

  always_ff @(posedge master_clk_i) begin
    lrst_s <= {lrst_s[0], reset_n_i};
    if (!link_rst_n) begin
      req_s <= 3'h0;
      cfg   <= CFG_RESET;
    end else begin
      req_s <= {req_s[1:0], req_tgl};
      if (req_s[1] ^ req_s[2]) cfg <= cfg_hold;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Master clock generation, audio domain.
  logic [10:0] fs_cnt;
  logic [10:0] bc_cnt;
  wire  [10:0] ratio_n = (cfg.ratio == 3'h1) ? `DAPSC_FS_128 :
                         (cfg.ratio == 3'h2) ? `DAPSC_FS_192 :
                         (cfg.ratio == 3'h3) ? `DAPSC_FS_256 :
                         (cfg.ratio == 3'h4) ? `DAPSC_FS_384 :
                         (cfg.ratio == 3'h5) ? `DAPSC_FS_512 :
                         (cfg.ratio == 3'h6) ? `DAPSC_FS_768 :
                         (cfg.ratio == 3'h7) ? `DAPSC_FS_1152 : `DAPSC_FS_AUTO;
  wire  [10:0] bit_per = (cfg.bdiv == 3'h1) ? `DAPSC_DIV8 :
                         (cfg.bdiv == 3'h2) ? (ratio_n >> `DAPSC_SH_32FS) :
                         (cfg.bdiv == 3'h3) ? (ratio_n >> `DAPSC_SH_64FS) :
                         (cfg.bdiv == 3'h4) ? (ratio_n >> `DAPSC_SH_128FS) :
                                              `DAPSC_DIV4;
  wire         is_dsp   = (cfg.fmt == dapsc_pkg::DAPSC_FMT_DSP);
  wire         is_i2s   = (cfg.fmt == dapsc_pkg::DAPSC_FMT_I2S);
  wire         fs_wrap  = (fs_cnt == 11'(ratio_n - 11'd1));
  wire         bc_wrap  = (bc_cnt == 11'(bit_per - 11'd1)) | fs_wrap;
  // The bit clock falls as each frame begins, so frame changes precede a rise.
  wire         bclk_gen = (bc_cnt >= (bit_per >> 1));
  wire         lr_flip  = cfg.lr_inv & ~is_dsp;
  wire         left_half = (fs_cnt < (ratio_n >> 1));
  wire         frame_gen = is_dsp ? (fs_cnt < bit_per) : ((left_half ^ is_i2s) ^ lr_flip);

  always_ff @(posedge master_clk_i) begin
    if (!link_rst_n || !cfg.master) begin
      fs_cnt <= 11'h000;
      bc_cnt <= 11'h000;
    end else begin
      fs_cnt <= fs_wrap ? 11'h000 : fs_cnt + 11'h001;
      bc_cnt <= bc_wrap ? 11'h000 : bc_cnt + 11'h001;
    end
  end

  always_ff @(posedge master_clk_i) begin
    if (!link_rst_n) begin
      bit_clock_o        <= 1'b0;
      frame_clock_o      <= 1'b0;
      bit_clock_oe_n_o   <= 1'b1;
      frame_clock_oe_n_o <= 1'b1;
    end else begin
      bit_clock_o        <= cfg.master & (bclk_gen ^ cfg.bclk_inv);
      frame_clock_o      <= cfg.master & frame_gen;
      bit_clock_oe_n_o   <= ~cfg.master;
      frame_clock_oe_n_o <= ~cfg.master;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Receiver. Own clocks pass a two-stage delay to line up with the data pin.
  logic [1:0]  bp_s;
  logic [1:0]  fp_s;
  logic [1:0]  dp_s;
  logic [1:0]  bo_d;
  logic [1:0]  fo_d;
  logic        b_prev;
  logic        f_prev;
  logic [6:0]  pos_cnt;
  logic [31:0] rx_sh;
  dapsc_pkg::dapsc_pair_t rx_pair;
  logic        pair_tgl;

  always_ff @(posedge master_clk_i) begin
    bp_s <= {bp_s[0], bit_clock_i};
    fp_s <= {fp_s[0], frame_clock_i};
    dp_s <= {dp_s[0], serial_audio_in_i};
    bo_d <= {bo_d[0], bit_clock_o};
    fo_d <= {fo_d[0], frame_clock_o};
  end

  wire        b_now   = cfg.master ? bo_d[1] : bp_s[1];
  wire        f_now   = (cfg.master ? fo_d[1] : fp_s[1]) ^ lr_flip;
  wire        strobe  = cfg.bclk_inv ? (~b_now & b_prev) : (b_now & ~b_prev);
  wire        trans   = is_dsp ? (f_now & ~f_prev) : (f_now ^ f_prev);
  wire [6:0]  pos     = trans ? `DAPSC_POS_FIRST :
                        (pos_cnt == `DAPSC_POS_MAX) ? pos_cnt : pos_cnt + 7'h01;
  wire [6:0]  wlen    = (cfg.wl == 2'h0) ? `DAPSC_WL16 : (cfg.wl == 2'h1) ? `DAPSC_WL20 :
                        (cfg.wl == 2'h2) ? `DAPSC_WL24 : `DAPSC_WL32;
  wire [31:0] wmask   = (cfg.wl == 2'h0) ? `DAPSC_MASK16 : (cfg.wl == 2'h1) ? `DAPSC_MASK20 :
                        (cfg.wl == 2'h2) ? `DAPSC_MASK24 : `DAPSC_MASK32;
  // Left justified and DSP mode B start on edge one; I2S and DSP mode A on two.
  wire        first_one = (cfg.fmt == dapsc_pkg::DAPSC_FMT_LJ) | (is_dsp & cfg.lr_inv);
  wire [6:0]  msb_pos = first_one ? `DAPSC_POS_FIRST : `DAPSC_POS_SECOND;
  wire [6:0]  end_l   = 7'(msb_pos + wlen - 7'h01);
  wire [6:0]  end_r   = 7'(end_l + wlen);
  wire        is_rj   = (cfg.fmt == dapsc_pkg::DAPSC_FMT_RJ);
  wire [31:0] sh_next = {rx_sh[30:0], dp_s[1]};
  wire        ch_left = is_i2s ? ~f_now : f_now;
  wire        rj_done = is_rj & trans;
  wire        fj_done = ~is_rj & (pos == end_l);
  wire        rj_left = f_prev;
  wire        put_l   = (rj_done & rj_left) | (fj_done & (is_dsp | ch_left));
  wire        put_r   = (rj_done & ~rj_left) | (fj_done & ~is_dsp & ~ch_left)
                        | (~is_rj & is_dsp & (pos == end_r));
  wire [31:0] word    = (is_rj ? rx_sh : sh_next) & wmask;
  wire        in_word = (pos >= msb_pos) & (pos <= (is_dsp ? end_r : end_l));

  always_ff @(posedge master_clk_i) begin
    if (!link_rst_n) begin
      b_prev   <= 1'b0;
      f_prev   <= 1'b0;
      pos_cnt  <= `DAPSC_POS_MAX;
      rx_sh    <= 32'h00000000;
      rx_pair  <= '0;
      pair_tgl <= 1'b0;
    end else begin
      b_prev <= b_now;
      if (strobe) begin
        f_prev  <= f_now;
        pos_cnt <= pos;
        if (is_rj || in_word) rx_sh <= sh_next;
        if (put_l) rx_pair.left <= word;
        if (put_r) rx_pair.right <= word;
        if (put_r) pair_tgl <= ~pair_tgl;
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Pair hand-back; a pair stays put for at least half a frame, far longer than the sync.
  logic [2:0] pt_s;

  always_ff @(posedge core_clk_i) begin
    if (!reset_n_i) begin
      pt_s           <= 3'h0;
      sample_left_o  <= 32'h00000000;
      sample_right_o <= 32'h00000000;
      sample_valid_o <= 1'b0;
    end else begin
      pt_s           <= {pt_s[1:0], pair_tgl};
      sample_valid_o <= pt_s[1] ^ pt_s[2];
      if (pt_s[1] ^ pt_s[2]) begin
        sample_left_o  <= rx_pair.left;
        sample_right_o <= rx_pair.right;
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Checks.
  reg_reset_a: assert property (@(posedge core_clk_i) disable iff (!reset_n_i)
    wr_reset |=> (aif1 == `DAPSC_AIF1_RESET) && (aif2 == `DAPSC_AIF2_RESET))
    else $error("register reset write left a register changed");
  vol_block_a: assert property (@(posedge core_clk_i) disable iff (!reset_n_i)
    commit && (wr_addr == `DAPSC_ADDR_VOLL || wr_addr == `DAPSC_ADDR_VOLR)
    |=> $stable(aif1) && $stable(aif2))
    else $error("volume address write altered the register file");
  id_read_a: assert property (@(posedge core_clk_i) disable iff (!reset_n_i)
    hdr_done && hdr_rw && hdr_addr == `DAPSC_ADDR_RESET |=> rd_active && rd_shift == PART_ID)
    else $error("identity read loaded a wrong value");
  rev_read_a: assert property (@(posedge core_clk_i) disable iff (!reset_n_i)
    hdr_done && hdr_rw && hdr_addr == `DAPSC_ADDR_REV |=> rd_shift == {13'h0000, SILICON_REV})
    else $error("revision read loaded a wrong value");
  shift_in_a: assert property (@(posedge core_clk_i) disable iff (!reset_n_i)
    spi_on && sclk_rise |=> shreg[0] == $past(sdi_s[1]) && shreg[23:1] == $past(shreg[22:0]))
    else $error("control bit not shifted in");
  read_bit_a: assert property (@(posedge core_clk_i) disable iff (!reset_n_i)
    rd_active && sclk_fall && !cs_s[1] |=> control_read_out_o == $past(rd_shift[15]))
    else $error("read data bit out of order");
  fmt_default_a: assert property (@(posedge core_clk_i)
    !reset_n_i |=> aif1[`DAPSC_FMT_LSB +: 2] == 2'h2 && aif1[`DAPSC_WL_LSB +: 2] == 2'h2
    && !aif1[`DAPSC_MSTR_BIT])
    else $error("format defaults wrong after reset");
  oe_slave_a: assert property (@(posedge master_clk_i) disable iff (!link_rst_n)
    !cfg.master ##1 !cfg.master |-> bit_clock_oe_n_o && frame_clock_oe_n_o && !bit_clock_o)
    else $error("clock pins driven in slave mode");
  bclk_out_a: assert property (@(posedge master_clk_i) disable iff (!link_rst_n)
    cfg.master |=> !bit_clock_oe_n_o && bit_clock_o == ($past(bclk_gen) ^ $past(cfg.bclk_inv)))
    else $error("master bit clock polarity wrong");

  read_frame_c: cover property (@(posedge core_clk_i) disable iff (!reset_n_i)
    hdr_done && hdr_rw);
  write_frame_c: cover property (@(posedge core_clk_i) disable iff (!reset_n_i)
    wr_aif1);
  pair_seen_c: cover property (@(posedge core_clk_i) disable iff (!reset_n_i)
    sample_valid_o);
  master_rx_c: cover property (@(posedge master_clk_i) disable iff (!link_rst_n)
    cfg.master && strobe && put_r);

endmodule : dapsc_top
`default_nettype wire

// ### dapsc_map.svh
// Purpose: Offsets, field positions, reset values and counts for the audio port block.
// Assumes: Included by the top module by bare name.
// Notes:   Definitions only.
`ifndef DAPSC_MAP_SVH
`define DAPSC_MAP_SVH
`define DAPSC_HDR_LAST    4'd7
`define DAPSC_RW_BIT      23
`define DAPSC_ADDR_LSB    16
`define DAPSC_ADDR_RESET  7'h00
`define DAPSC_ADDR_REV    7'h01
`define DAPSC_ADDR_AIF1   7'h03
`define DAPSC_ADDR_AIF2   7'h04
`define DAPSC_ADDR_VOLL   7'h06
`define DAPSC_ADDR_VOLR   7'h07
`define DAPSC_AIF1_RESET  16'h0012
`define DAPSC_AIF2_RESET  16'h0000
`define DAPSC_AIF1_MASK   16'h00fb
`define DAPSC_AIF2_MASK   16'h003f
`define DAPSC_FMT_LSB     0
`define DAPSC_WL_LSB      3
`define DAPSC_BINV_BIT    5
`define DAPSC_LINV_BIT    6
`define DAPSC_MSTR_BIT    7
`define DAPSC_RATIO_LSB   0
`define DAPSC_BDIV_LSB    3
`define DAPSC_FS_AUTO     11'd256
`define DAPSC_FS_128      11'd128
`define DAPSC_FS_192      11'd192
`define DAPSC_FS_256      11'd256
`define DAPSC_FS_384      11'd384
`define DAPSC_FS_512      11'd512
`define DAPSC_FS_768      11'd768
`define DAPSC_FS_1152     11'd1152
`define DAPSC_DIV4        11'd4
`define DAPSC_DIV8        11'd8
`define DAPSC_SH_32FS     5
`define DAPSC_SH_64FS     6
`define DAPSC_SH_128FS    7
`define DAPSC_WL16        7'd16
`define DAPSC_WL20        7'd20
`define DAPSC_WL24        7'd24
`define DAPSC_WL32        7'd32
`define DAPSC_MASK16      32'h0000ffff
`define DAPSC_MASK20      32'h000fffff
`define DAPSC_MASK24      32'h00ffffff
`define DAPSC_MASK32      32'hffffffff
`define DAPSC_POS_FIRST   7'd1
`define DAPSC_POS_SECOND  7'd2
`define DAPSC_POS_MAX     7'h7f
`endif

// ### dapsc_pkg.sv
// Purpose: Types shared by the audio port block.
// Assumes: Nothing beyond the map header.
// Notes:   Holds types only; numbers live in the map header.
`default_nettype none
package dapsc_pkg;
  typedef enum logic [1:0] {
    DAPSC_FMT_RJ  = 2'h0,
    DAPSC_FMT_LJ  = 2'h1,
    DAPSC_FMT_I2S = 2'h2,
    DAPSC_FMT_DSP = 2'h3
  } dapsc_fmt_t;

  typedef enum logic [1:0] {
    DAPSC_SPI_IDLE = 2'h0,
    DAPSC_SPI_HEAD = 2'h1,
    DAPSC_SPI_BODY = 2'h3
  } dapsc_spi_t;

  typedef struct packed {
    logic       master;
    logic       lr_inv;
    logic       bclk_inv;
    logic [1:0] wl;
    dapsc_fmt_t fmt;
    logic [2:0] bdiv;
    logic [2:0] ratio;
  } dapsc_cfg_t;

  typedef struct packed {
    logic [31:0] left;
    logic [31:0] right;
  } dapsc_pair_t;
endpackage : dapsc_pkg
`default_nettype wire

// ### dapsc_host_model.sv
// Purpose: Host audio source driving the port as a slave in I2S.
// Assumes: Bit clock is master clock over eight; 32 slots per channel.
// Notes:   Unused slots carry a toggling pattern so a misplaced sample shows.
`timescale 1ns/1ps
`default_nettype none
module dapsc_host_model #(
  parameter logic [23:0] LEFT_WORD  = 24'ha5c3e1,
  parameter logic [23:0] RIGHT_WORD = 24'h1b2d3f
) (
  input  wire logic master_clk_i,
  input  wire logic run_i,
  output logic      bit_clock_o,
  output logic      frame_clock_o,
  output logic      serial_audio_o
);
  logic [1:0]  div;
  logic [4:0]  slot;
  logic [4:0]  next_slot;
  logic        next_frame;
  logic [23:0] word;
  assign next_slot  = slot + 5'h01;
  assign next_frame = (slot == 5'h1f) ? ~frame_clock_o : frame_clock_o;
  assign word       = next_frame ? RIGHT_WORD : LEFT_WORD;
  always_ff @(posedge master_clk_i) begin
    div <= run_i ? div + 2'h1 : 2'h0;
    if (!run_i) begin
      bit_clock_o    <= 1'b0;
      frame_clock_o  <= 1'b1;
      slot           <= 5'h1f;
      serial_audio_o <= 1'b0;
    end else if (div == 2'h3) begin
      bit_clock_o <= ~bit_clock_o;
      // Data and frame move on the falling edge; the device takes them on the rising one.
      if (bit_clock_o) begin
        slot           <= next_slot;
        frame_clock_o  <= next_frame;
        // The MSB lands one slot after the frame change, so at the second rising edge.
        serial_audio_o <= (next_slot >= 5'd1 && next_slot <= 5'd24) ?
                          word[5'd24 - next_slot] : ~serial_audio_o;
      end
    end
  end
endmodule : dapsc_host_model
`default_nettype wire

// ### dac_audio_port_and_spi_control_tb.sv
// Purpose: Self-checking bench for the control port and audio input.
// Assumes: Control pins change 2 ns after a core clock edge.
// Notes:   Shift clock half periods are five core cycles.
`timescale 1ns/1ps
`default_nettype none
module dac_audio_port_and_spi_control_tb;
  localparam logic [15:0] ID  = 16'h3c96;  // Arbitrary identity value.
  localparam logic [2:0]  REV = 3'h5;      // Arbitrary revision value.
  logic        core_clk, mclk, rst_n, sck, sdi, cs_n, run, ok;
  logic        rd_o, bclk_dev, bclk_oe_n, fclk_dev, fclk_oe_n, valid, bclk_h, fclk_h, sdata;
  logic [31:0] left, right;
  logic [15:0] rdata;
  int          bad_count, checks_done;
  wire logic   bclk_w = bclk_oe_n ? bclk_h : bclk_dev;
  wire logic   fclk_w = fclk_oe_n ? fclk_h : fclk_dev;
  dapsc_top #(.PART_ID(ID), .SILICON_REV(REV)) dapsc_top_i (.core_clk_i(core_clk),
    .reset_n_i(rst_n), .master_clk_i(mclk), .control_port_select_i(1'b1),
    .control_shift_clock_i(sck), .control_data_in_i(sdi), .control_select_n_i(cs_n),
    .serial_audio_in_i(sdata), .bit_clock_i(bclk_w), .frame_clock_i(fclk_w),
    .control_read_out_o(rd_o), .bit_clock_o(bclk_dev), .bit_clock_oe_n_o(bclk_oe_n),
    .frame_clock_o(fclk_dev), .frame_clock_oe_n_o(fclk_oe_n), .sample_left_o(left),
    .sample_right_o(right), .sample_valid_o(valid));
  dapsc_host_model dapsc_host_model_i (.master_clk_i(mclk), .run_i(run),
    .bit_clock_o(bclk_h), .frame_clock_o(fclk_h), .serial_audio_o(sdata));
  always #20 core_clk = ~core_clk;
  initial begin
    mclk = 1'b0;
    #17;
    forever #62.5 mclk = ~mclk;
  end
  ////////////////////////////////////////////////////////////////////////////
  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", checks_done, bad_count);
    if (bad_count == 0 && checks_done > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask : tally_and_finish
  task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
    checks_done++;
    if (got !== exp) begin
      bad_count++;
      $display("[ERR] %s expected %h seen %h", what, exp, got);
    end
  endtask : check
  task automatic cyc(input int n);
    repeat (n) @(posedge core_clk);
    #2;
  endtask : cyc
  // Read data is sampled just before each rising shift edge, as a host would.
  task automatic spi(input logic rw, input logic [6:0] addr, input logic [15:0] data);
    logic [23:0] frame;
    frame = {rw, addr, data};
    cs_n = 1'b0;
    for (int i = 23; i >= 0; i--) begin
      sdi = frame[i];
      cyc(5);
      if (i < 16) rdata[i] = rd_o;
      sck = 1'b1;
      cyc(5);
      sck = 1'b0;
    end
    cyc(5);
    cs_n = 1'b1;
    cyc(8);
  endtask : spi
  // Data-in is all ones after the address; the device must ignore it.
  task automatic reg_read(input string what, input logic [6:0] a, input logic [15:0] exp);
    spi(1'b1, a, 16'hffff);
    check(what, {16'h0000, exp}, {16'h0000, rdata});
  endtask : reg_read
  task automatic wait_valid();
    ok = 1'b0;
    for (int n = 0; n < 5000 && !ok; n++) begin
      cyc(1);
      ok = (valid === 1'b1);
    end
    if (!ok) begin
      check("sample_valid", 32'h1, 32'h0);
      tally_and_finish();
    end
  endtask : wait_valid
  ////////////////////////////////////////////////////////////////////////////
  task automatic test_reset_values();
    reg_read("audio_port_control", 7'h03, 16'h0012);
    reg_read("clock_ratio_control", 7'h04, 16'h0000);
    reg_read("part_identifier", 7'h00, ID);
    reg_read("silicon_rev_number", 7'h01, {13'h0000, REV});
    $display("test_reset_values done");
  endtask : test_reset_values
  task automatic test_refused();
    spi(1'b0, 7'h06, 16'h1234);
    reg_read("volume_left", 7'h06, 16'h0000);
    spi(1'b0, 7'h07, 16'h0321);
    reg_read("volume_right", 7'h07, 16'h0000);
    spi(1'b0, 7'h01, 16'h0002);
    reg_read("silicon_rev_number", 7'h01, {13'h0000, REV});
    $display("test_refused done");
  endtask : test_refused
  // The host stops while the format is changed; a live change may garble audio.
  task automatic test_write_reset();
    run = 1'b0;
    spi(1'b0, 7'h03, 16'hff7f);
    reg_read("audio_port_control", 7'h03, 16'h007b);
    spi(1'b0, 7'h04, 16'hffff);
    reg_read("clock_ratio_control", 7'h04, 16'h003f);
    spi(1'b0, 7'h00, 16'h1234);
    reg_read("audio_port_control", 7'h03, 16'h0012);
    reg_read("clock_ratio_control", 7'h04, 16'h0000);
    run = 1'b1;
    $display("test_write_reset done");
  endtask : test_write_reset
  // The first pair may start mid-frame, so the second one is judged.
  task automatic test_slave_i2s();
    wait_valid();
    wait_valid();
    check("sample_left", 32'h00a5c3e1, left);
    check("sample_right", 32'h001b2d3f, right);
    $display("test_slave_i2s done");
  endtask : test_slave_i2s
  // Default ratio runs at 256fs: one frame is 256 master cycles, 800 core cycles.
  task automatic test_master();
    int   hi_b;
    int   edges;
    int   first;
    int   last;
    int   per;
    logic prev;
    hi_b = 0;
    edges = 0;
    first = 0;
    last = 0;
    per = 0;
    prev = 1'b1;
    spi(1'b0, 7'h03, 16'h0092);
    for (int n = 0; n < 100 && bclk_oe_n !== 1'b0; n++) cyc(1);
    check("bit_clock_oe_n", 32'h0, {31'h0, bclk_oe_n});
    check("frame_clock_oe_n", 32'h0, {31'h0, fclk_oe_n});
    for (int n = 0; n < 2000; n++) begin
      cyc(1);
      if (bclk_dev === 1'b1) hi_b++;
      if (fclk_dev === 1'b1 && prev === 1'b0) begin
        edges++;
        if (edges == 1) first = n;
        last = n;
      end
      prev = fclk_dev;
    end
    if (edges > 1) per = (last - first) / (edges - 1);
    check("bit_clock_duty", 32'h1, {31'h0, (hi_b > 900 && hi_b < 1100)});
    check("frame_clock_period", 32'h1, {31'h0, (per >= 799 && per <= 801)});
    $display("test_master done");
  endtask : test_master
  initial begin
    core_clk = 1'b0;
    rst_n = 1'b0;
    {sck, sdi, run, bad_count, checks_done} = '0;
    cs_n = 1'b1;
    repeat (4) @(posedge mclk);
    @(posedge core_clk);
    #2;
    rst_n = 1'b1;
    run = 1'b1;
    test_reset_values();
    test_refused();
    test_write_reset();
    test_slave_i2s();
    test_master();
    tally_and_finish();
  end
endmodule : dac_audio_port_and_spi_control_tb
`default_nettype wire
